// ### design/nvhc_pkg.sv
// Purpose: shared constants, types and timing helpers for the nv-backed sram host controller
// Assumes: 250 MHz clock, word-wide (x16) memory organisation
// Notes:   long transfer times are top-level parameters; short access times live here
package nvhc_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////
    // widths and clock
    localparam int ADDR_W   = 18;   // 262,144 words
    localparam int DATA_W   = 16;
    localparam int LANE_W   = 2;
    localparam int CNT_W    = 24;
    localparam int CLK_NS   = 4;
    localparam int SEQ_LEN  = 6;

    // short pin timings in ns (plain defaults)
    localparam int ADDRESS_ACCESS_TIME_NS = 20;
    localparam int WRITE_DATA_SETUP_NS    = 10;
    localparam int WRITE_PULSE_NS         = 15;
    localparam int SYNC_STAGES            = 2;
    localparam int SETTLE_CYC             = 3;   // lets the busy line pass the synchroniser

    // least time in ns to whole cycles, never under one
    function automatic int ns_to_cyc_min(input int ns);
        int r;
        r = (ns + CLK_NS - 1) / CLK_NS;
        if (r < 1) begin
            r = 1;
        end
        return r;
    endfunction

    // read cycles include the two-stage data synchroniser
    localparam int READ_CYC  = ns_to_cyc_min(ADDRESS_ACCESS_TIME_NS) + SYNC_STAGES;
    localparam int WRITE_CYC = (ns_to_cyc_min(WRITE_PULSE_NS) > ns_to_cyc_min(WRITE_DATA_SETUP_NS))
                               ? ns_to_cyc_min(WRITE_PULSE_NS)
                               : ns_to_cyc_min(WRITE_DATA_SETUP_NS);

    ////////////////////////////////////////////////////////////////////////////////////////
    // arming prefix and final step of the software sequence
    localparam logic [15:0] SEQ_ARM0   = 16'h4E38;
    localparam logic [15:0] SEQ_ARM1   = 16'hB1C7;
    localparam logic [15:0] SEQ_ARM2   = 16'h83E0;
    localparam logic [15:0] SEQ_ARM3   = 16'h7C1F;
    localparam logic [15:0] SEQ_ARM4   = 16'h703F;
    localparam logic [15:0] SEQ_STORE  = 16'h8FC0;
    localparam logic [15:0] SEQ_RECALL = 16'h4C63;
    localparam logic [2:0]  SEQ_LAST   = 3'h5;

    ////////////////////////////////////////////////////////////////////////////////////////
    // user commands
    typedef enum logic [2:0] {
        OP_READ      = 3'b000,
        OP_WRITE     = 3'b001,
        OP_SW_STORE  = 3'b010,
        OP_SW_RECALL = 3'b011,
        OP_HW_STORE  = 3'b100
    } nvhc_op_type;

    typedef struct packed {
        nvhc_op_type              op;
        logic [ADDR_W-1:0]        addr;
        logic [DATA_W-1:0]        wdata;
        logic [LANE_W-1:0]        lane_n;  // [1] upper, [0] lower, active low
    } nvhc_cmd_type;

    // pins driven toward the memory
    typedef struct packed {
        logic [ADDR_W-1:0]        addr;
        logic                     chip_select_n;
        logic                     output_drive_n;
        logic                     write_strobe_n;
        logic                     upper_byte_sel_n;
        logic                     lower_byte_sel_n;
        logic [DATA_W-1:0]        dq_o;
        logic                     dq_oe;
        logic                     save_busy_oe;  // pulls the open-drain line low
    } nvhc_pins_type;

    localparam nvhc_pins_type PINS_IDLE = '{
        addr: '0, chip_select_n: 1'b1, output_drive_n: 1'b1, write_strobe_n: 1'b1,
        upper_byte_sel_n: 1'b1, lower_byte_sel_n: 1'b1, dq_o: '0, dq_oe: 1'b0,
        save_busy_oe: 1'b0};

    typedef enum logic [3:0] {
        ST_POWERUP   = 4'b0000,
        ST_IDLE      = 4'b0001,
        ST_READ      = 4'b0010,
        ST_WRITE     = 4'b0011,
        ST_WRITE_END = 4'b0100,
        ST_SEQ       = 4'b0101,
        ST_SEQ_GAP   = 4'b0110,
        ST_XFER      = 4'b0111,
        ST_HW_HOLD   = 4'b1000,
        ST_WAIT_HIGH = 4'b1001
    } nvhc_state_type;

    typedef struct packed {
        nvhc_state_type           state;
        logic [CNT_W-1:0]         cnt;
        logic [2:0]               idx;
        logic                     recall;
        logic                     ready;
        logic                     rsp_valid;
        logic [DATA_W-1:0]        rdata;
        nvhc_pins_type            pins;
    } nvhc_ctl_type;

endpackage

// ### design/nvhc_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk_in
// Notes:   the first stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
module nvhc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } nvhc_sync_type;

    nvhc_sync_type sync_r;
    nvhc_sync_type sync_nxt;

    // shift the pin value through both stages
    always_comb begin
        sync_nxt.first  = async_in;
        sync_nxt.second = sync_r.first;
    end

    // registers, released to the idle-high level
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync_r <= '1;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r.second;
endmodule
`default_nettype wire

// ### design/nvhc_ctrl.sv
// Purpose: host controller driving an nv-backed sram through its pins
// Assumes: word-wide part; save_busy_n is open drain with an external pull-up
// Notes:   one command at a time; results come back as a one-cycle rsp_valid_out
`timescale 1ns/1ns
`default_nettype none
module nvhc_ctrl #(
    parameter int SAVE_ENTRY_DELAY_NS         = 25000,
    parameter int SAVE_DURATION_NS            = 8000000,
    parameter int RESTORE_DURATION_NS         = 200000,
    parameter int POWERUP_RESTORE_DURATION_NS = 20000000
) (
    input  wire logic                           clk_in,
    input  wire logic                           rst_in,
    input  wire logic                           cmd_valid_in,
    input  wire nvhc_pkg::nvhc_cmd_type         cmd_in,
    output logic                                cmd_ready_out,
    output logic                                rsp_valid_out,
    output logic [nvhc_pkg::DATA_W-1:0]         rsp_rdata_out,
    output nvhc_pkg::nvhc_pins_type             pins_out,
    input  wire logic [nvhc_pkg::DATA_W-1:0]    dq_in,
    input  wire logic                           save_busy_n_in
);
    import nvhc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////////
    // cycle counts of the long times
    localparam int ENTRY_CYC   = ns_to_cyc_min(SAVE_ENTRY_DELAY_NS);
    localparam int SAVE_CYC    = ns_to_cyc_min(SAVE_DURATION_NS);
    localparam int RESTORE_CYC = ns_to_cyc_min(RESTORE_DURATION_NS);
    localparam int PU_CYC      = ns_to_cyc_min(POWERUP_RESTORE_DURATION_NS);

    nvhc_ctl_type         st_r;
    nvhc_ctl_type         st_nxt;
    logic [DATA_W:0]      pin_sync;
    logic [DATA_W-1:0]    dq_sync;
    logic                 busy_low;

    // data and busy line pass two flip-flops before use
    nvhc_sync #(
        .WIDTH (DATA_W + 1)
    ) u_sync (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .async_in ({save_busy_n_in, dq_in}),
        .sync_out (pin_sync)
    );

    assign dq_sync  = pin_sync[DATA_W-1:0];
    assign busy_low = ~pin_sync[DATA_W];

    ////////////////////////////////////////////////////////////////////////////////////////
    // address of each sequence step, upper bits zero
    function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] idx, input logic rec);
        logic [15:0] v;
        case (idx)
            3'h0:    v = SEQ_ARM0;
            3'h1:    v = SEQ_ARM1;
            3'h2:    v = SEQ_ARM2;
            3'h3:    v = SEQ_ARM3;
            3'h4:    v = SEQ_ARM4;
            default: v = rec ? SEQ_RECALL : SEQ_STORE;
        endcase
        return {{(ADDR_W-16){1'b0}}, v};
    endfunction

    // put one chip-select controlled sequence read on the pins
    function automatic nvhc_pins_type seq_pins(input logic [2:0] idx, input logic rec);
        nvhc_pins_type p;
        p                  = PINS_IDLE;
        p.addr             = seq_addr(idx, rec);
        p.chip_select_n    = 1'b0;
        p.output_drive_n   = 1'b0;
        p.upper_byte_sel_n = 1'b0;
        p.lower_byte_sel_n = 1'b0;
        return p;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        st_nxt           = st_r;
        st_nxt.rsp_valid = 1'b0;
        case (st_r.state)
            // wait out the power-up restore, then for the busy line to rise
            ST_POWERUP: begin
                if (st_r.cnt != '0) begin
                    st_nxt.cnt = st_r.cnt - 1'b1;
                end else if (!busy_low) begin
                    st_nxt.state = ST_IDLE;
                    st_nxt.ready = 1'b1;
                end
            end
            // accept a command only while the busy line is high
            ST_IDLE: begin
                st_nxt.ready = !busy_low;
                if (cmd_valid_in && st_r.ready && !busy_low) begin
                    st_nxt.ready = 1'b0;
                    case (cmd_in.op)
                        OP_READ: begin
                            st_nxt.pins.addr             = cmd_in.addr;
                            st_nxt.pins.chip_select_n    = 1'b0;
                            st_nxt.pins.output_drive_n   = 1'b0;
                            st_nxt.pins.upper_byte_sel_n = cmd_in.lane_n[1];
                            st_nxt.pins.lower_byte_sel_n = cmd_in.lane_n[0];
                            st_nxt.cnt                   = CNT_W'(READ_CYC);
                            st_nxt.state                 = ST_READ;
                        end
                        OP_WRITE: begin
                            st_nxt.pins.addr             = cmd_in.addr;
                            st_nxt.pins.chip_select_n    = 1'b0;
                            st_nxt.pins.write_strobe_n   = 1'b0;
                            st_nxt.pins.output_drive_n   = 1'b1;
                            st_nxt.pins.upper_byte_sel_n = cmd_in.lane_n[1];
                            st_nxt.pins.lower_byte_sel_n = cmd_in.lane_n[0];
                            st_nxt.pins.dq_o             = cmd_in.wdata;
                            st_nxt.pins.dq_oe            = 1'b1;
                            st_nxt.cnt                   = CNT_W'(WRITE_CYC);
                            st_nxt.state                 = ST_WRITE;
                        end
                        OP_SW_STORE, OP_SW_RECALL: begin
                            st_nxt.recall = (cmd_in.op == OP_SW_RECALL);
                            st_nxt.idx    = 3'h0;
                            st_nxt.pins   = seq_pins(3'h0, cmd_in.op == OP_SW_RECALL);
                            st_nxt.cnt    = CNT_W'(READ_CYC);
                            st_nxt.state  = ST_SEQ;
                        end
                        OP_HW_STORE: begin
                            st_nxt.pins.save_busy_oe = 1'b1;
                            st_nxt.cnt               = CNT_W'(ENTRY_CYC);
                            st_nxt.state             = ST_HW_HOLD;
                        end
                        default: begin
                            st_nxt.ready = 1'b1;  // unknown code is dropped
                        end
                    endcase
                end
            end
            // hold the read selected until the data has settled and been sampled
            ST_READ: begin
                if (st_r.cnt != '0) begin
                    st_nxt.cnt = st_r.cnt - 1'b1;
                end else begin
                    st_nxt.rdata     = dq_sync;
                    st_nxt.pins      = PINS_IDLE;
                    st_nxt.rsp_valid = 1'b1;
                    st_nxt.state     = ST_IDLE;
                end
            end
            // strobe ends first, address and data held one cycle past it
            ST_WRITE: begin
                if (st_r.cnt != '0) begin
                    st_nxt.cnt = st_r.cnt - 1'b1;
                end else begin
                    st_nxt.pins.write_strobe_n = 1'b1;
                    st_nxt.state               = ST_WRITE_END;
                end
            end
            ST_WRITE_END: begin
                st_nxt.pins      = PINS_IDLE;
                st_nxt.rsp_valid = 1'b1;
                st_nxt.state     = ST_IDLE;
            end
            // one sequence step; no other access may slip in between
            ST_SEQ: begin
                if (st_r.cnt != '0) begin
                    st_nxt.cnt = st_r.cnt - 1'b1;
                end else begin
                    st_nxt.pins = PINS_IDLE;
                    if (st_r.idx == SEQ_LAST) begin
                        st_nxt.cnt   = st_r.recall ? CNT_W'(RESTORE_CYC) : CNT_W'(SAVE_CYC);
                        st_nxt.state = ST_XFER;
                    end else begin
                        st_nxt.idx   = st_r.idx + 3'h1;
                        st_nxt.state = ST_SEQ_GAP;
                    end
                end
            end
            // chip select high for one cycle between steps
            ST_SEQ_GAP: begin
                st_nxt.pins  = seq_pins(st_r.idx, st_r.recall);
                st_nxt.cnt   = CNT_W'(READ_CYC);
                st_nxt.state = ST_SEQ;
            end
            // transfer running: bus stays idle
            ST_XFER: begin
                if (st_r.cnt != '0) begin
                    st_nxt.cnt = st_r.cnt - 1'b1;
                end else begin
                    st_nxt.cnt   = CNT_W'(SETTLE_CYC);
                    st_nxt.state = ST_WAIT_HIGH;
                end
            end
            // pull the line for the entry delay, then let go
            ST_HW_HOLD: begin
                if (st_r.cnt != '0) begin
                    st_nxt.cnt = st_r.cnt - 1'b1;
                end else begin
                    st_nxt.pins.save_busy_oe = 1'b0;
                    st_nxt.cnt               = CNT_W'(SETTLE_CYC);
                    st_nxt.state             = ST_WAIT_HIGH;
                end
            end
            // device may keep the line low while it saves, or skip the save
            ST_WAIT_HIGH: begin
                if (st_r.cnt != '0) begin
                    st_nxt.cnt = st_r.cnt - 1'b1;
                end else if (!busy_low) begin
                    st_nxt.rsp_valid = 1'b1;
                    st_nxt.ready     = 1'b1;
                    st_nxt.state     = ST_IDLE;
                end
            end
            default: begin
                st_nxt       = st_r;
                st_nxt.pins  = PINS_IDLE;
                st_nxt.state = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r           <= '0;
            st_r.state     <= ST_POWERUP;
            st_r.cnt       <= CNT_W'(PU_CYC);
            st_r.pins      <= PINS_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign cmd_ready_out = st_r.ready;
    assign rsp_valid_out = st_r.rsp_valid;
    assign rsp_rdata_out = st_r.rdata;
    assign pins_out      = st_r.pins;
endmodule
`default_nettype wire

// ### tb/nvhc_ctrl_assertions.sv
// Purpose: pin and command port checks for the host controller
// Assumes: bound to nvhc_ctrl; sequence addresses are never read as plain data
// Notes:   one clock domain, reset disables every check
`timescale 1ns/1ns
`default_nettype none
module nvhc_chk #(
    parameter int SAVE_ENTRY_DELAY_NS = 25000
) (
    input wire logic                    clk_in,
    input wire logic                    rst_in,
    input wire logic                    cmd_ready_out,
    input wire nvhc_pkg::nvhc_pins_type pins_out,
    input wire logic                    save_busy_n_in
);
    import nvhc_pkg::*;
    localparam int ENTRY_CYC = (SAVE_ENTRY_DELAY_NS + 3) / 4;
    int          hold_r;
    logic [15:0] last_rd_r;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    ////////////////////////////////////////////////////////////////////////////////
    // length of the host pull on the busy line, and address of the last access
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hold_r <= 0;
            last_rd_r <= '0;
        end else begin
            hold_r <= pins_out.save_busy_oe ? hold_r + 1 : 0;
            if ($fell(pins_out.chip_select_n)) last_rd_r <= pins_out.addr[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // access shapes
    read_shape_a: assert property (!pins_out.chip_select_n && !pins_out.output_drive_n |->
        pins_out.write_strobe_n && !pins_out.save_busy_oe) else $error("bad read strobes");
    read_hold_a: assert property ($fell(pins_out.output_drive_n) |=>
        $stable(pins_out.addr)[*6]) else $error("read address moved");
    write_shape_a: assert property (!pins_out.write_strobe_n |->
        !pins_out.chip_select_n && pins_out.dq_oe) else $error("write without select");
    write_hold_a: assert property (!pins_out.write_strobe_n |=>
        $stable(pins_out.addr) && $stable(pins_out.dq_o)) else $error("write moved");
    write_setup_a: assert property ($rose(pins_out.write_strobe_n) |->
        !$past(pins_out.write_strobe_n, 3)) else $error("write pulse short");
    no_contend_a: assert property (!pins_out.write_strobe_n |->
        pins_out.output_drive_n) else $error("output drive low in write");
    data_drive_a: assert property (pins_out.dq_oe |->
        !pins_out.chip_select_n && pins_out.output_drive_n) else $error("stray data drive");
    // busy line blocks the bus
    busy_block_a: assert property ((!save_busy_n_in)[*5] |=>
        !$fell(pins_out.chip_select_n) && !cmd_ready_out) else $error("access while busy");
    pin_hold_a: assert property ($fell(pins_out.save_busy_oe) |->
        hold_r == ENTRY_CYC + 1) else $error("wrong pull length");
    pull_idle_a: assert property (pins_out.save_busy_oe |->
        pins_out.chip_select_n) else $error("access during pull");
    seq_order_a: assert property ($fell(pins_out.chip_select_n) &&
        (pins_out.addr[15:0] == SEQ_STORE || pins_out.addr[15:0] == SEQ_RECALL) |->
        last_rd_r == SEQ_ARM4) else $error("sequence out of order");
    // main scenarios
    cover property ($fell(pins_out.save_busy_oe));
    cover property ($rose(pins_out.write_strobe_n));
    cover property ($fell(pins_out.chip_select_n) && pins_out.addr[15:0] == SEQ_RECALL);
endmodule
bind nvhc_ctrl nvhc_chk #(.SAVE_ENTRY_DELAY_NS(SAVE_ENTRY_DELAY_NS)) chk (
    .clk_in(clk_in), .rst_in(rst_in), .cmd_ready_out(cmd_ready_out),
    .pins_out(pins_out), .save_busy_n_in(save_busy_n_in));
`default_nettype wire

// ### tb/nvhc_sram_model.sv
// Purpose: behavioural nv-backed word-wide sram facing the host controller pins
// Assumes: the bench clock paces transfer timers; busy line has a pull-up
// Notes:   released data lanes show the inverse of the last wire value
`timescale 1ns/1ns
`default_nettype none
module nvhc_sram_model #(
    parameter int SAVE_CYC    = 100,
    parameter int RESTORE_CYC = 50,
    parameter int ENTRY_CYC   = 10,
    parameter int PU_CYC      = 40
) (
    input  wire logic                    clk_in,
    input  wire nvhc_pkg::nvhc_pins_type pins_in,
    output logic [15:0]                  dq_out,
    output logic                         busy_n_out
);
    import nvhc_pkg::*;
    logic [15:0] sram [logic [17:0]];
    logic [15:0] nv [logic [17:0]];
    logic [15:0] last_r = 16'hA5C3;
    logic [15:0] word;
    logic        drv_r = 1'b1;
    logic        pend_r = 1'b0;
    logic        cs_r = 1'b1;
    logic        we_r = 1'b1;
    logic        rd;
    int          blk_r = PU_CYC;
    int          low_r = 0;
    int          idx_r = 0;
    int          save_count = 0;
    logic [15:0] arm [0:4] = '{SEQ_ARM0, SEQ_ARM1, SEQ_ARM2, SEQ_ARM3, SEQ_ARM4};

    ////////////////////////////////////////////////////////////////////////////////
    // open-drain busy wire and the read path
    assign busy_n_out = !(drv_r || pins_in.save_busy_oe);
    assign rd = !pins_in.chip_select_n && !pins_in.output_drive_n && pins_in.write_strobe_n
                && busy_n_out && blk_r == 0;
    always_comb begin
        word = sram.exists(pins_in.addr) ? sram[pins_in.addr] : 16'h0000;
        dq_out = pins_in.dq_oe ? pins_in.dq_o : ~last_r;
        if (rd && !pins_in.upper_byte_sel_n) dq_out[15:8] = word[15:8];
        if (rd && !pins_in.lower_byte_sel_n) dq_out[7:0] = word[7:0];
    end

    // copy into the nonvolatile array and hold the busy line meanwhile
    task automatic start_save();
        nv = sram;
        save_count++;
        pend_r <= 1'b0;
        drv_r <= 1'b1;
        blk_r <= SAVE_CYC;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // writes, pin requests and the six-read sequence
    always @(posedge clk_in) begin
        last_r <= dq_out;
        cs_r <= pins_in.chip_select_n;
        we_r <= pins_in.write_strobe_n;
        if (blk_r > 0) begin
            blk_r <= blk_r - 1;
            if (blk_r == 1) drv_r <= 1'b0;
        end else if (!busy_n_out) begin
            low_r <= low_r + 1;
            if (low_r == ENTRY_CYC && pend_r) start_save();
        end else begin
            low_r <= 0;
            if (!we_r && pins_in.write_strobe_n && !pins_in.chip_select_n) begin
                if (!sram.exists(pins_in.addr)) sram[pins_in.addr] = 16'h0000;
                if (!pins_in.upper_byte_sel_n) sram[pins_in.addr][15:8] = dq_out[15:8];
                if (!pins_in.lower_byte_sel_n) sram[pins_in.addr][7:0] = dq_out[7:0];
                pend_r <= 1'b1;
            end
            if (cs_r && !pins_in.chip_select_n) begin
                if (!pins_in.write_strobe_n) idx_r <= 0;
                else if (idx_r < 5) idx_r <= (pins_in.addr[14:2] == arm[idx_r][14:2]) ?
                                             idx_r + 1 : 0;
                else begin
                    idx_r <= 0;
                    if (pins_in.addr[14:2] == SEQ_STORE[14:2]) start_save();
                    if (pins_in.addr[14:2] == SEQ_RECALL[14:2]) begin
                        sram = nv;
                        pend_r <= 1'b0;
                        blk_r <= RESTORE_CYC;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/nvhc_ctrl_bench.sv
// Purpose: self-checking bench for the nv-backed sram host controller
// Assumes: transfer times shortened through the controller parameters
// Notes:   the memory model counts saves so that skipped saves can be seen
`timescale 1ns/1ns
`default_nettype none
module nvhc_ctrl_bench;
    import nvhc_pkg::*;
    localparam int SAVE_CYC = 100;
    localparam int RESTORE_CYC = 50;
    localparam int ENTRY_CYC = 10;     // matches the controller's entry delay of 40 ns
    localparam int PU_CYC = 40;        // model busy time from time zero, reset included
    logic              clk_in = 1'b0;
    logic              rst_in = 1'b1;
    logic              cmd_valid_in = 1'b0;
    nvhc_cmd_type      cmd_in = '0;
    logic              cmd_ready_out;
    logic              rsp_valid_out;
    logic [DATA_W-1:0] rsp_rdata_out;
    nvhc_pins_type     pins_out;
    logic [DATA_W-1:0] dq_wire;
    logic              busy_wire;
    logic [DATA_W-1:0] q;
    int                fails = 0;
    int                check_count = 0;
    int                cycles = 0;
    int                cyc;
    int                base;
`define CHECK_EQ(what, exp, got) begin check_count++; if ((got) !== (exp)) begin fails++; \
    $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end

    nvhc_ctrl #(.SAVE_ENTRY_DELAY_NS(40), .SAVE_DURATION_NS(400), .RESTORE_DURATION_NS(200),
        .POWERUP_RESTORE_DURATION_NS(100)) uut (.clk_in(clk_in), .rst_in(rst_in),
        .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out),
        .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out), .pins_out(pins_out),
        .dq_in(dq_wire), .save_busy_n_in(busy_wire));
    nvhc_sram_model #(.SAVE_CYC(SAVE_CYC), .RESTORE_CYC(RESTORE_CYC), .ENTRY_CYC(ENTRY_CYC),
        .PU_CYC(PU_CYC)) dev (.clk_in(clk_in), .pins_in(pins_out), .dq_out(dq_wire),
        .busy_n_out(busy_wire));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #2 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // one command: hold valid until taken, then wait for the response pulse
    task automatic do_cmd(input nvhc_op_type op, input logic [17:0] a, input logic [15:0] d,
                          input logic [1:0] ln);
        int n;
        @(posedge clk_in);
        #1;
        cmd_in = '{op: op, addr: a, wdata: d, lane_n: ln};
        cmd_valid_in = 1'b1;
        n = 0;
        while (cmd_ready_out !== 1'b1 && n < 3000) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        @(posedge clk_in);
        #1;
        cmd_valid_in = 1'b0;
        cyc = 0;
        while (rsp_valid_out !== 1'b1 && cyc < 3000) begin
            @(posedge clk_in);
            #1;
            cyc++;
        end
        q = rsp_rdata_out;
        `CHECK_EQ("response", 1'b1, rsp_valid_out)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_powerup();
        int n;
        n = 0;
        while (cmd_ready_out !== 1'b1 && n < 500) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        `CHECK_EQ("powerup wait", 1'b1, n >= PU_CYC - 6)
    endtask

    task automatic t_lanes();
        do_cmd(OP_WRITE, 18'h3_FFFF, 16'h1234, 2'b00);
        do_cmd(OP_WRITE, 18'h3_FFFF, 16'hABCD, 2'b01);
        do_cmd(OP_WRITE, 18'h0_0002, 16'h5A5A, 2'b00);
        do_cmd(OP_READ, 18'h3_FFFF, 16'h0000, 2'b00);
        `CHECK_EQ("upper lane", 16'hAB34, q)
        do_cmd(OP_READ, 18'h0_0002, 16'h0000, 2'b10);
        `CHECK_EQ("lower lane", 8'h5A, q[7:0])
    endtask

    task automatic t_soft();
        base = dev.save_count;
        do_cmd(OP_WRITE, 18'h0_0010, 16'hCAFE, 2'b00);
        do_cmd(OP_SW_STORE, '0, '0, 2'b00);
        `CHECK_EQ("save ran", base + 1, dev.save_count)
        `CHECK_EQ("save wait", 1'b1, cyc >= SAVE_CYC)
        do_cmd(OP_WRITE, 18'h0_0010, 16'hBEEF, 2'b00);
        do_cmd(OP_SW_RECALL, '0, '0, 2'b00);
        `CHECK_EQ("restore wait", 1'b1, cyc >= RESTORE_CYC)
        do_cmd(OP_READ, 18'h0_0010, '0, 2'b00);
        `CHECK_EQ("restored word", 16'hCAFE, q)
        do_cmd(OP_SW_STORE, '0, '0, 2'b00);
        `CHECK_EQ("unconditional save", base + 2, dev.save_count)
    endtask

    task automatic t_pin_save();
        base = dev.save_count;
        do_cmd(OP_WRITE, 18'h0_0020, 16'h7777, 2'b00);
        do_cmd(OP_HW_STORE, '0, '0, 2'b00);
        `CHECK_EQ("pin save ran", base + 1, dev.save_count)
        `CHECK_EQ("pin save wait", 1'b1, cyc >= SAVE_CYC)
        do_cmd(OP_HW_STORE, '0, '0, 2'b00);
        `CHECK_EQ("pin save skipped", base + 1, dev.save_count)
        `CHECK_EQ("short release", 1'b1, cyc < SAVE_CYC)
        do_cmd(OP_READ, 18'h0_0020, '0, 2'b00);
        `CHECK_EQ("word kept", 16'h7777, q)
    endtask

    initial begin
        repeat (6) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        t_powerup();
        t_lanes();
        t_soft();
        t_pin_save();
        complete_run();
    end
endmodule
`default_nettype wire
